/* pkg/phy_regs_pkg.sv */
package phy_regs_pkg;

  // Register addresses on the management interface
  localparam logic [4:0] REG_PARTNER_ABILITY = 5'h06;
  localparam logic [4:0] REG_NP_TX = 5'h07;
  localparam logic [4:0] REG_NP_RX = 5'h08;
  localparam logic [4:0] REG_RXER_CNT = 5'h15;
  localparam logic [4:0] REG_IRQ = 5'h1B;
  localparam logic [4:0] REG_CABLE = 5'h1D;
  localparam logic [4:0] REG_PHY_CTRL = 5'h1F;

  // Field positions and widths
  localparam int PA_PD_FAULT = 4;
  localparam int PA_LP_NP_ABLE = 3;
  localparam int PA_NP_ABLE = 2;
  localparam int PA_PAGE_RCVD = 1;
  localparam int PA_LP_AN_ABLE = 0;
  localparam int NP_NEXT = 15;
  localparam int NP_ACK = 14;
  localparam int NP_MSG_PAGE = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOGGLE = 11;
  localparam int NP_MSG_W = 11;
  localparam int IRQ_EN_LSB = 8;
  localparam int IRQ_N = 8;
  localparam int CABLE_START = 15;
  localparam int CABLE_RES_LSB = 13;
  localparam int CABLE_DIST_W = 9;
  localparam int CTRL_IRQ_LEVEL = 9;

  // Reset values, counter limit and fixed ability value
  localparam logic NP_MSG_PAGE_RST = 1'b1;
  localparam logic [NP_MSG_W-1:0] NP_MSG_RST = 11'h001;
  localparam logic [15:0] RXER_CNT_RST = 16'h0000;
  localparam logic [15:0] RXER_CNT_MAX = 16'hFFFF;
  localparam logic NP_ABLE_VALUE = 1'b1;

  // Management frame timing in management clock bits, opcodes and PHY address
  localparam logic [5:0] MDIO_PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] MDIO_HDR_LAST = 5'h0C;
  localparam logic [4:0] MDIO_DATA_LAST = 5'h0F;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [4:0] PHY_ADDR = 5'h01;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  // Field order matches the flag order 7..0
  typedef struct packed {
    logic jabber;
    logic rx_err;
    logic page_rcvd;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } link_evt_t;

  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_HEADER,
    ST_TA,
    ST_READ,
    ST_WRITE
  } mdio_state_t;

endpackage : phy_regs_pkg

/* src/mdio_frame.sv */
`timescale 1ns/1ps
module mdio_frame
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Register side
  input wire logic [15:0] rdata_i,
  output mgmt_req_t req_o
);

  logic mdc_s1, mdc_s2, mdc_q, mdio_s1, mdio_s2;
  logic rise;
  mdio_state_t state;
  logic [5:0] ones;
  logic [4:0] cnt;
  logic [11:0] hdr;
  logic [12:0] hdr_full;
  logic [15:0] sh;
  logic is_read;

  // Pin synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_q <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1 <= mdc_i;
      mdc_s2 <= mdc_s1;
      mdc_q <= mdc_s2;
      mdio_s1 <= mdio_i;
      mdio_s2 <= mdio_s1;
    end
  end

  assign rise = mdc_s2 & ~mdc_q;
  assign hdr_full = {hdr, mdio_s2};

  // Frame sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= ST_PREAMBLE;
      ones <= 6'h00;
      cnt <= 5'h00;
      hdr <= 12'h000;
      is_read <= 1'b0;
      req_o <= '0;
    end else begin
      req_o.rd <= 1'b0;
      req_o.wr <= 1'b0;
      if (rise) begin
        unique case (state)
          ST_PREAMBLE: begin
            if (mdio_s2) begin
              if (ones != MDIO_PREAMBLE_BITS) ones <= ones + 6'h01;
            end else begin
              if (ones == MDIO_PREAMBLE_BITS) state <= ST_HEADER;
              ones <= 6'h00;
              cnt <= 5'h00;
            end
          end
          ST_HEADER: begin
            hdr <= hdr_full[11:0];
            cnt <= cnt + 5'h01;
            if (cnt == MDIO_HDR_LAST) begin
              cnt <= 5'h00;
              req_o.addr <= hdr_full[4:0];
              if (hdr_full[12] && hdr_full[9:5] == PHY_ADDR && hdr_full[11:10] == MDIO_OP_READ) begin
                req_o.rd <= 1'b1;
                is_read <= 1'b1;
                state <= ST_TA;
              end else if (hdr_full[12] && hdr_full[9:5] == PHY_ADDR && hdr_full[11:10] == MDIO_OP_WRITE) begin
                is_read <= 1'b0;
                state <= ST_TA;
              end else begin
                state <= ST_PREAMBLE;
              end
            end
          end
          ST_TA: begin
            cnt <= cnt + 5'h01;
            if (cnt != 5'h00) begin
              cnt <= 5'h00;
              state <= is_read ? ST_READ : ST_WRITE;
            end
          end
          ST_READ: begin
            cnt <= cnt + 5'h01;
            if (cnt == MDIO_DATA_LAST) state <= ST_PREAMBLE;
          end
          ST_WRITE: begin
            cnt <= cnt + 5'h01;
            if (cnt == MDIO_DATA_LAST) begin
              req_o.wr <= 1'b1;
              req_o.wdata <= {sh[14:0], mdio_s2};
              state <= ST_PREAMBLE;
            end
          end
        endcase
      end
    end
  end

  // Data shifter and pin driver
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sh <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (req_o.rd) begin
      sh <= rdata_i;
    end else if (rise) begin
      if (state == ST_TA && is_read && cnt == 5'h00) begin
        mdio_oe_o <= 1'b1;
        mdio_o <= 1'b0;
      end else if ((state == ST_TA && is_read) || (state == ST_READ && cnt != MDIO_DATA_LAST)) begin
        mdio_o <= sh[15];
        sh <= {sh[14:0], 1'b0};
      end else if (state == ST_READ) begin
        mdio_oe_o <= 1'b0;
        mdio_o <= 1'b0;
      end else if (state == ST_WRITE) begin
        sh <= {sh[14:0], mdio_s2};
      end
    end
  end

endmodule : mdio_frame

/* src/phy_nextpage_irq_cabletest_regs.sv */
`timescale 1ns/1ps
module phy_nextpage_irq_cabletest_regs
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Auto-negotiation status
  input wire logic partner_np_able_i,
  input wire logic partner_an_able_i,
  input wire logic [15:0] partner_np_word_i,
  input wire logic np_sent_i,
  output logic [15:0] np_tx_word_o,
  // Link events
  input wire link_evt_t link_evt_i,
  // Interrupt pin
  output logic irq_o,
  // Cable diagnostic
  input wire logic cable_done_i,
  input wire logic [1:0] cable_result_i,
  input wire logic [CABLE_DIST_W-1:0] cable_dist_i,
  output logic cable_start_o
);

  mgmt_req_t req;
  logic [15:0] rdata;
  logic rd_pa, rd_irq, wr_np, wr_irq, wr_cable, wr_ctrl;
  logic pd_fault, page_rcvd;
  logic np_next, np_msg_page, np_ack2, tx_toggle;
  logic [NP_MSG_W-1:0] np_msg;
  logic [15:0] rx_np;
  logic [15:0] rxer_cnt;
  logic [IRQ_N-1:0] irq_en, irq_flag, evt;
  logic irq_level, irq_active;
  logic cable_busy;
  logic [1:0] cable_result;
  logic [CABLE_DIST_W-1:0] cable_dist;
  link_evt_t flag_view;

  mdio_frame u_mdio_frame (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .rdata_i(rdata),
    .req_o(req)
  );

  assign rd_pa = req.rd && req.addr == REG_PARTNER_ABILITY;
  assign rd_irq = req.rd && req.addr == REG_IRQ;
  assign wr_np = req.wr && req.addr == REG_NP_TX;
  assign wr_irq = req.wr && req.addr == REG_IRQ;
  assign wr_cable = req.wr && req.addr == REG_CABLE;
  assign wr_ctrl = req.wr && req.addr == REG_PHY_CTRL;
  assign evt = link_evt_i;
  assign irq_active = |(irq_flag & irq_en);
  assign flag_view = irq_flag;

  // Latching-high status, event wins over read clear
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pd_fault <= 1'b0;
      page_rcvd <= 1'b0;
    end else begin
      pd_fault <= link_evt_i.pd_fault | (pd_fault & ~rd_pa);
      page_rcvd <= link_evt_i.page_rcvd | (page_rcvd & ~rd_pa);
    end
  end

  // Transmit next page register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      np_next <= 1'b0;
      np_msg_page <= NP_MSG_PAGE_RST;
      np_ack2 <= 1'b0;
      np_msg <= NP_MSG_RST;
    end else if (wr_np) begin
      np_next <= req.wdata[NP_NEXT];
      np_msg_page <= req.wdata[NP_MSG_PAGE];
      np_ack2 <= req.wdata[NP_ACK2];
      np_msg <= req.wdata[NP_MSG_W-1:0];
    end
  end

  // Toggle, opposite to that of the previously sent page
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tx_toggle <= 1'b0;
    end else if (np_sent_i) begin
      tx_toggle <= ~tx_toggle;
    end
  end

  assign np_tx_word_o = {np_next, 1'b0, np_msg_page, np_ack2, tx_toggle, np_msg};

  // Received partner next page, captured with each page
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rx_np <= 16'h0000;
    end else if (link_evt_i.page_rcvd) begin
      rx_np <= partner_np_word_i;
    end
  end

  // Receive error counter, saturating
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rxer_cnt <= RXER_CNT_RST;
    end else if (link_evt_i.rx_err && rxer_cnt != RXER_CNT_MAX) begin
      rxer_cnt <= rxer_cnt + 16'h0001;
    end
  end

  // Interrupt enables and level
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_en <= '0;
      irq_level <= 1'b0;
    end else begin
      if (wr_irq) irq_en <= req.wdata[IRQ_EN_LSB +: IRQ_N];
      if (wr_ctrl) irq_level <= req.wdata[CTRL_IRQ_LEVEL];
    end
  end

  // Event flags, set wins over read clear
  genvar k;
  generate
    for (k = 0; k < IRQ_N; k++) begin : g_flag
      always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          irq_flag[k] <= 1'b0;
        end else begin
          irq_flag[k] <= evt[k] | (irq_flag[k] & ~rd_irq);
        end
      end
    end
  endgenerate

  // Interrupt pin with selectable polarity
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b1;
    end else begin
      irq_o <= irq_level ? irq_active : ~irq_active;
    end
  end

  // Cable diagnostic control
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cable_busy <= 1'b0;
      cable_start_o <= 1'b0;
      cable_result <= 2'h0;
      cable_dist <= '0;
    end else begin
      cable_start_o <= 1'b0;
      if (cable_done_i) begin
        cable_busy <= 1'b0;
        cable_result <= cable_result_i;
        cable_dist <= cable_dist_i;
      end
      if (wr_cable && req.wdata[CABLE_START] && !cable_busy) begin
        cable_busy <= 1'b1;
        cable_start_o <= 1'b1;
      end
    end
  end

  // Read data
  always_comb begin
    rdata = 16'h0000;
    unique case (req.addr)
      REG_PARTNER_ABILITY: begin
        rdata[PA_PD_FAULT] = pd_fault;
        rdata[PA_LP_NP_ABLE] = partner_np_able_i;
        rdata[PA_NP_ABLE] = NP_ABLE_VALUE;
        rdata[PA_PAGE_RCVD] = page_rcvd;
        rdata[PA_LP_AN_ABLE] = partner_an_able_i;
      end
      REG_NP_TX: rdata = np_tx_word_o;
      REG_NP_RX: rdata = rx_np;
      REG_RXER_CNT: rdata = rxer_cnt;
      REG_IRQ: rdata = {irq_en, irq_flag};
      REG_CABLE: begin
        rdata[CABLE_START] = cable_busy;
        rdata[CABLE_RES_LSB +: 2] = cable_result;
        rdata[CABLE_DIST_W-1:0] = cable_dist;
      end
      REG_PHY_CTRL: rdata[CTRL_IRQ_LEVEL] = irq_level;
      default: rdata = 16'h0000;
    endcase
  end

  // Checks
  property p_pd_fault_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      link_evt_i.pd_fault ##1 (!rd_pa) [*2] |=> pd_fault;
  endproperty
  a_pd_fault_hold: assert property (p_pd_fault_hold) else $error("fault bit lost");

  property p_pa_read_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      rd_pa && !link_evt_i.page_rcvd && !link_evt_i.pd_fault |=> !page_rcvd && !pd_fault;
  endproperty
  a_pa_read_clear: assert property (p_pa_read_clear) else $error("latched bits not cleared");

  property p_np_able;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      req.addr == REG_PARTNER_ABILITY |-> rdata[PA_NP_ABLE] && rdata[15:5] == 11'h000;
  endproperty
  a_np_able: assert property (p_np_able) else $error("next page able not 1");

  property p_np_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      wr_np |=> np_tx_word_o[NP_NEXT] == $past(req.wdata[NP_NEXT])
        && np_tx_word_o[NP_MSG_W-1:0] == $past(req.wdata[NP_MSG_W-1:0]) && !np_tx_word_o[NP_ACK];
  endproperty
  a_np_write: assert property (p_np_write) else $error("next page write lost");

  property p_toggle;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      np_sent_i |=> tx_toggle != $past(tx_toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not flipped");

  property p_rx_page;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      link_evt_i.page_rcvd ##1 !link_evt_i.page_rcvd |-> rx_np == $past(partner_np_word_i);
  endproperty
  a_rx_page: assert property (p_rx_page) else $error("partner page not captured");

  property p_rxer;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      link_evt_i.rx_err && rxer_cnt != RXER_CNT_MAX |=> rxer_cnt == $past(rxer_cnt) + 16'h0001;
  endproperty
  a_rxer: assert property (p_rxer) else $error("error counter missed");

  property p_flag_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      evt != '0 |=> (irq_flag & $past(evt)) == $past(evt);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_flag_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      rd_irq && evt == '0 |=> irq_flag == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");

  property p_irq_pin;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      irq_active && irq_level ##1 irq_active && irq_level |=> irq_o ##1 (!irq_active && irq_level) [*2] |=> !irq_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");

  property p_irq_low;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (!irq_level && !irq_active) [*2] |-> irq_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("idle active-low pin not high");

  property p_cable_start;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      wr_cable && req.wdata[CABLE_START] && !cable_busy |=> cable_start_o && cable_busy ##1 !cable_start_o;
  endproperty
  a_cable_start: assert property (p_cable_start) else $error("cable test not started");

  property p_cable_done;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      cable_done_i && !wr_cable |=> !cable_busy && cable_result == $past(cable_result_i)
        && cable_dist == $past(cable_dist_i);
  endproperty
  a_cable_done: assert property (p_cable_done) else $error("cable result not captured");

  property p_np_fields;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      wr_np |=> np_tx_word_o[NP_MSG_PAGE] == $past(req.wdata[NP_MSG_PAGE])
        && np_tx_word_o[NP_ACK2] == $past(req.wdata[NP_ACK2]);
  endproperty
  a_np_fields: assert property (p_np_fields) else $error("page type or second acknowledge lost");

  property p_np_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !wr_np |=> $stable(np_msg);
  endproperty
  a_np_hold: assert property (p_np_hold) else $error("message field changed without write");

  property p_rxer_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !link_evt_i.rx_err |=> $stable(rxer_cnt);
  endproperty
  a_rxer_hold: assert property (p_rxer_hold) else $error("error counter moved without error");

  property p_en_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      wr_irq |=> irq_en == $past(req.wdata[IRQ_EN_LSB +: IRQ_N]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("interrupt enables not written");

  property p_link_down;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      link_evt_i.link_down |=> flag_view.link_down;
  endproperty
  a_link_down: assert property (p_link_down) else $error("link down flag not set");

  property p_cable_busy;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      cable_busy && !cable_done_i |=> cable_busy;
  endproperty
  a_cable_busy: assert property (p_cable_busy) else $error("test start bit cleared early");

  c_irq_read: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) irq_active ##[1:50] rd_irq);
  c_np_write: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) wr_np);
  c_cable: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) cable_start_o ##[1:200] cable_done_i);
  c_rxer: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) link_evt_i.rx_err ##1 rxer_cnt != RXER_CNT_RST);
  c_pa_read: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) rd_pa && (pd_fault || page_rcvd));

endmodule : phy_nextpage_irq_cabletest_regs

/* verification/mgmt_host.sv */
`timescale 1ns/1ps
module mgmt_host
  import phy_regs_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Management pins
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  // Clock stands low and the data line is released outside frames
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // One management clock period of ten system cycles; sample on the rise
  task automatic clk_bit(input logic drive, input logic val, output logic seen);
    @(posedge sys_clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= drive;
    mdio_o <= drive ? val : ~mdio_o;
    repeat (5) @(posedge sys_clk_i);
    mdc_o <= 1'b1;
    seen = mdio_i;
    repeat (4) @(posedge sys_clk_i);
  endtask : clk_bit

  // Full frame with its own preamble; read releases the line from turnaround on
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic s;
    logic [13:0] hdr;
    hdr = {2'b01, (rd ? MDIO_OP_READ : MDIO_OP_WRITE), PHY_ADDR, addr};
    for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
    clk_bit(!rd, 1'b1, s);
    clk_bit(!rd, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      clk_bit(!rd, wdata[i], s);
      rdata[i] = s;
    end
    @(posedge sys_clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
  endtask : xfer
endmodule : mgmt_host

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import phy_regs_pkg::*;
  logic sys_clk;
  logic nrst;
  logic mdc, host_d, host_oe, dut_d, dut_oe, mdio_wire;
  logic np_able, an_able, np_sent, irq, cable_done, cable_start;
  logic [15:0] np_word, np_tx, rd;
  logic [1:0] cable_res;
  logic [8:0] cable_dist;
  link_evt_t evt;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int starts = 0;

  // Pull-up on the shared data line
  assign mdio_wire = dut_oe ? dut_d : (host_oe ? host_d : 1'b1);

  phy_nextpage_irq_cabletest_regs u_dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .mdc_i(mdc), .mdio_i(mdio_wire), .mdio_o(dut_d),
    .mdio_oe_o(dut_oe), .partner_np_able_i(np_able), .partner_an_able_i(an_able),
    .partner_np_word_i(np_word), .np_sent_i(np_sent), .np_tx_word_o(np_tx), .link_evt_i(evt),
    .irq_o(irq), .cable_done_i(cable_done), .cable_result_i(cable_res), .cable_dist_i(cable_dist),
    .cable_start_o(cable_start));

  mgmt_host u_host (.sys_clk_i(sys_clk), .mdio_i(mdio_wire), .mdc_o(mdc), .mdio_o(host_d),
    .mdio_oe_o(host_oe));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Start pulses are counted; the cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cable_start === 1'b1) starts <= starts + 1;
    if (cycles == 60000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_reg(input logic [4:0] addr, input logic [15:0] exp);
    u_host.xfer(1'b1, addr, 16'h0000, rd);
    check(rd, exp);
  endtask : rd_reg

  task automatic wr_reg(input logic [4:0] addr, input logic [15:0] data);
    u_host.xfer(1'b0, addr, data, rd);
  endtask : wr_reg

  task automatic pulse(input link_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
  endtask : pulse

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic test_done();
    $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    nrst = 1'b0;
    np_able = 1'b0;
    an_able = 1'b0;
    np_sent = 1'b0;
    np_word = 16'h0000;
    evt = '0;
    cable_done = 1'b0;
    cable_res = 2'h0;
    cable_dist = 9'h000;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;

    check({15'h0000, irq}, 16'h0001);
    check(np_tx, 16'h2001);
    rd_reg(REG_PARTNER_ABILITY, 16'h0004);
    rd_reg(REG_NP_TX, 16'h2001);
    rd_reg(REG_NP_RX, 16'h0000);
    rd_reg(REG_RXER_CNT, 16'h0000);
    rd_reg(REG_IRQ, 16'h0000);
    rd_reg(REG_CABLE, 16'h0000);
    rd_reg(REG_PHY_CTRL, 16'h0000);
    rd_reg(5'h0A, 16'h0000);
    $display("test reset values done");

    @(posedge sys_clk);
    np_able <= 1'b1;
    an_able <= 1'b1;
    rd_reg(REG_PARTNER_ABILITY, 16'h000D);
    wr_reg(REG_NP_TX, 16'hFFFF);
    rd_reg(REG_NP_TX, 16'hB7FF);
    check(np_tx, 16'hB7FF);
    wr_reg(REG_NP_TX, 16'h0000);
    @(posedge sys_clk);
    np_sent <= 1'b1;
    @(posedge sys_clk);
    np_sent <= 1'b0;
    rd_reg(REG_NP_TX, 16'h0800);
    check(np_tx, 16'h0800);
    $display("test next page transmit done");

    @(posedge sys_clk);
    np_word <= 16'hF805;
    pulse(8'h30);
    rd_reg(REG_NP_RX, 16'hF805);
    rd_reg(REG_PARTNER_ABILITY, 16'h001F);
    rd_reg(REG_PARTNER_ABILITY, 16'h000D);
    rd_reg(REG_IRQ, 16'h0030);
    $display("test page received done");

    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      settle();
      check({15'h0000, irq}, 16'h0001);
      rd_reg(REG_IRQ, 16'h0001 << i);
      rd_reg(REG_IRQ, 16'h0000);
    end
    pulse(8'h01);
    pulse(8'h04);
    rd_reg(REG_IRQ, 16'h0005);
    pulse(8'h40);
    pulse(8'h40);
    rd_reg(REG_RXER_CNT, 16'h0003);
    rd_reg(REG_IRQ, 16'h0040);
    $display("test event flags done");

    wr_reg(REG_IRQ, 16'h04FF);
    rd_reg(REG_IRQ, 16'h0400);
    pulse(8'h01);
    settle();
    check({15'h0000, irq}, 16'h0001);
    rd_reg(REG_IRQ, 16'h0401);
    pulse(8'h04);
    settle();
    check({15'h0000, irq}, 16'h0000);
    rd_reg(REG_IRQ, 16'h0404);
    check({15'h0000, irq}, 16'h0001);
    wr_reg(REG_PHY_CTRL, 16'h0200);
    check({15'h0000, irq}, 16'h0000);
    rd_reg(REG_PHY_CTRL, 16'h0200);
    pulse(8'h04);
    settle();
    check({15'h0000, irq}, 16'h0001);
    rd_reg(REG_IRQ, 16'h0404);
    check({15'h0000, irq}, 16'h0000);
    $display("test interrupt pin done");

    for (int r = 0; r < 4; r++) begin
      wr_reg(REG_CABLE, 16'h8000);
      u_host.xfer(1'b1, REG_CABLE, 16'h0000, rd);
      check({15'h0000, rd[15]}, 16'h0001);
      @(posedge sys_clk);
      cable_res <= r[1:0];
      cable_dist <= {r[1:0], 7'h7F};
      cable_done <= 1'b1;
      @(posedge sys_clk);
      cable_done <= 1'b0;
      rd_reg(REG_CABLE, {1'b0, r[1:0], 4'h0, r[1:0], 7'h7F});
    end
    check(starts[15:0], 16'h0004);
    $display("test cable diagnostic done");
    test_done();
  end
endmodule : testbench
